// *** common/gpio_port_map.vh ***
// Register map, field layout and reset values of the GPIO data registers
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

// ----------------------------------------
// Bus widths
// ----------------------------------------
`define GPIO_ADDR_W 16
`define GPIO_DATA_W 8

// ----------------------------------------
// Pins per port
// ----------------------------------------
`define PORT_A_W 6
`define PORT_B_W 8
`define PORT_C_W 8
`define PORT_D_W 5

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PORT_B_OUTPUT_ADDR 16'h0080
`define PORT_A_INPUT_ADDR 16'h0084
`define PORT_B_INPUT_ADDR 16'h0085
`define PORT_C_INPUT_ADDR 16'h0086
`define PORT_D_INPUT_ADDR 16'h008e
`define PORT_C_OUTPUT_ADDR 16'h0090
`define PORT_D_OUTPUT_ADDR 16'h0098
`define PORT_A_OUTPUT_ADDR 16'h00b0
`define PORT_D_RESET_RETENTION_ADDR 16'h202f
`define PORT_A_DIRECTION_ADDR 16'h2030
`define PORT_B_DIRECTION_ADDR 16'h2031
`define PORT_C_DIRECTION_ADDR 16'h2032
`define PORT_D_DIRECTION_ADDR 16'h2033

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define RETAIN_BIT 0
`define RETAIN_RST 1'b0
`define OUTPUT_RST_BIT 1'b0
`define DIRECTION_RST_BIT 1'b1
`define ANALOG_READ_BIT 1'b1
`define READ_IDLE 8'h00

`endif

// *** rtl/gpio_pin_slice.v ***
// One port of pins: output and direction registers, input path, pad drive
`timescale 1ns/1ps
`include "gpio_port_map.vh"

module gpio_pin_slice #(
   parameter W = 8
) (
   input wire clk,
   input wire srst,
   input wire hold,
   input wire wr_out,
   input wire wr_dir,
   input wire [W-1:0] wdata,
   input wire [W-1:0] pin_in,
   input wire [W-1:0] analog_sel,
   output wire [W-1:0] out_value,
   output wire [W-1:0] dir_value,
   output wire [W-1:0] in_level,
   output wire [W-1:0] pin_out,
   output wire [W-1:0] pin_oe
);

   reg [W-1:0] out_q;
   reg [W-1:0] dir_q;

   // ----------------------------------------
   // Output level and direction storage
   // ----------------------------------------
   // Hold keeps both registers through a reset; writes wait for reset release
   always @(posedge clk) begin
      if (srst) begin
         if (!hold) begin
            out_q <= {W{`OUTPUT_RST_BIT}};
            dir_q <= {W{`DIRECTION_RST_BIT}};
         end
      end else begin
         if (wr_out) begin
            out_q <= wdata;
         end
         if (wr_dir) begin
            dir_q <= wdata;
         end
      end
   end

   // ----------------------------------------
   // Pad side
   // ----------------------------------------
   // Analog pins read as one whatever the pad shows
   assign in_level = pin_in | analog_sel;
   // Drive only where direction says output
   assign pin_oe = ~dir_q;
   assign pin_out = out_q;
   assign out_value = out_q;
   assign dir_value = dir_q;

endmodule // gpio_pin_slice

// *** rtl/gpio_port_data_registers.v ***
// Data registers of a four-port GPIO block with port D reset retention
`timescale 1ns/1ps
`include "gpio_port_map.vh"

module gpio_port_data_registers (
   input wire clk,
   input wire srst,
   // Register port
   input wire [`GPIO_ADDR_W-1:0] addr,
   input wire [`GPIO_DATA_W-1:0] wdata,
   input wire wr,
   input wire rd,
   output wire [`GPIO_DATA_W-1:0] rdata,
   // Port A pads
   input wire [`PORT_A_W-1:0] port_a_in,
   input wire [`PORT_A_W-1:0] port_a_analog_sel,
   output wire [`PORT_A_W-1:0] port_a_out,
   output wire [`PORT_A_W-1:0] port_a_oe,
   // Port B pads
   input wire [`PORT_B_W-1:0] port_b_in,
   input wire [`PORT_B_W-1:0] port_b_analog_sel,
   output wire [`PORT_B_W-1:0] port_b_out,
   output wire [`PORT_B_W-1:0] port_b_oe,
   // Port C pads
   input wire [`PORT_C_W-1:0] port_c_in,
   input wire [`PORT_C_W-1:0] port_c_analog_sel,
   output wire [`PORT_C_W-1:0] port_c_out,
   output wire [`PORT_C_W-1:0] port_c_oe,
   // Port D pads
   input wire [`PORT_D_W-1:0] port_d_in,
   input wire [`PORT_D_W-1:0] port_d_analog_sel,
   output wire [`PORT_D_W-1:0] port_d_out,
   output wire [`PORT_D_W-1:0] port_d_oe
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   reg retain_q;
   reg [`GPIO_DATA_W-1:0] rdata_q;
   reg [`GPIO_DATA_W-1:0] rdata_d;
   reg hold_q;
   reg port_d_hold;

   wire wr_a_out;
   wire wr_b_out;
   wire wr_c_out;
   wire wr_d_out;
   wire wr_a_dir;
   wire wr_b_dir;
   wire wr_c_dir;
   wire wr_d_dir;
   wire wr_retain;
   wire hit_a_in;
   wire hit_b_in;
   wire hit_c_in;
   wire hit_d_in;
   wire hit_a_out;
   wire hit_b_out;
   wire hit_c_out;
   wire hit_d_out;
   wire hit_a_dir;
   wire hit_b_dir;
   wire hit_c_dir;
   wire hit_d_dir;
   wire hit_retain;

   wire [`PORT_A_W-1:0] a_out_value;
   wire [`PORT_B_W-1:0] b_out_value;
   wire [`PORT_C_W-1:0] c_out_value;
   wire [`PORT_D_W-1:0] d_out_value;
   wire [`PORT_A_W-1:0] a_dir_value;
   wire [`PORT_B_W-1:0] b_dir_value;
   wire [`PORT_C_W-1:0] c_dir_value;
   wire [`PORT_D_W-1:0] d_dir_value;
   wire [`PORT_A_W-1:0] a_in_level;
   wire [`PORT_B_W-1:0] b_in_level;
   wire [`PORT_C_W-1:0] c_in_level;
   wire [`PORT_D_W-1:0] d_in_level;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // One comparator per register, shared by the write and read paths except for the input registers, which only the read path uses
   assign hit_a_in = (addr == `PORT_A_INPUT_ADDR);
   assign hit_b_in = (addr == `PORT_B_INPUT_ADDR);
   assign hit_c_in = (addr == `PORT_C_INPUT_ADDR);
   assign hit_d_in = (addr == `PORT_D_INPUT_ADDR);

   // Stored output levels
   assign hit_a_out = (addr == `PORT_A_OUTPUT_ADDR);
   assign hit_b_out = (addr == `PORT_B_OUTPUT_ADDR);
   assign hit_c_out = (addr == `PORT_C_OUTPUT_ADDR);
   assign hit_d_out = (addr == `PORT_D_OUTPUT_ADDR);

   // Direction and retention control
   assign hit_a_dir = (addr == `PORT_A_DIRECTION_ADDR);
   assign hit_b_dir = (addr == `PORT_B_DIRECTION_ADDR);
   assign hit_c_dir = (addr == `PORT_C_DIRECTION_ADDR);
   assign hit_d_dir = (addr == `PORT_D_DIRECTION_ADDR);
   assign hit_retain = (addr == `PORT_D_RESET_RETENTION_ADDR);

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   // Input registers have no write decode, so writes to them fall away
   assign wr_a_out = wr && hit_a_out;
   assign wr_b_out = wr && hit_b_out;
   assign wr_c_out = wr && hit_c_out;
   assign wr_d_out = wr && hit_d_out;

   // Direction registers, one per port
   assign wr_a_dir = wr && hit_a_dir;
   assign wr_b_dir = wr && hit_b_dir;
   assign wr_c_dir = wr && hit_c_dir;
   assign wr_d_dir = wr && hit_d_dir;

   // Retention control
   assign wr_retain = wr && hit_retain;

   // ----------------------------------------
   // Port D reset retention
   // ----------------------------------------
   // The control bit itself clears at the first reset edge; software must
   // set it again before the next reset if port D is to be kept once more
   always @(posedge clk) begin
      if (srst) begin
         retain_q <= `RETAIN_RST;
      end else if (wr_retain) begin
         retain_q <= wdata[`RETAIN_BIT];
      end
   end

   // ----------------------------------------
   // Port D hold across a long reset
   // ----------------------------------------
   // The flag carries an armed hold over every further edge of one reset,
   // since the control bit is already cleared after the first edge
   always @(posedge clk) begin
      if (srst) begin
         hold_q <= port_d_hold;
      end else begin
         hold_q <= 1'b0;
      end
   end

   // Hold comes from the bit at the first reset edge, from the flag after;
   // plain ifs so a bit never set at power-up lets port D clear
   always @* begin
      port_d_hold = 1'b0;
      if (retain_q) begin
         port_d_hold = 1'b1;
      end
      if (hold_q) begin
         port_d_hold = 1'b1;
      end
   end

   // ----------------------------------------
   // Port slices
   // ----------------------------------------
   // Ports A to C never hold through reset
   gpio_pin_slice #(
      .W(`PORT_A_W)
   ) u_port_a (
      .clk(clk),
      .srst(srst),
      .hold(1'b0),
      .wr_out(wr_a_out),
      .wr_dir(wr_a_dir),
      .wdata(wdata[`PORT_A_W-1:0]),
      .pin_in(port_a_in),
      .analog_sel(port_a_analog_sel),
      .out_value(a_out_value),
      .dir_value(a_dir_value),
      .in_level(a_in_level),
      .pin_out(port_a_out),
      .pin_oe(port_a_oe)
   );

   gpio_pin_slice #(
      .W(`PORT_B_W)
   ) u_port_b (
      .clk(clk),
      .srst(srst),
      .hold(1'b0),
      .wr_out(wr_b_out),
      .wr_dir(wr_b_dir),
      .wdata(wdata[`PORT_B_W-1:0]),
      .pin_in(port_b_in),
      .analog_sel(port_b_analog_sel),
      .out_value(b_out_value),
      .dir_value(b_dir_value),
      .in_level(b_in_level),
      .pin_out(port_b_out),
      .pin_oe(port_b_oe)
   );

   gpio_pin_slice #(
      .W(`PORT_C_W)
   ) u_port_c (
      .clk(clk),
      .srst(srst),
      .hold(1'b0),
      .wr_out(wr_c_out),
      .wr_dir(wr_c_dir),
      .wdata(wdata[`PORT_C_W-1:0]),
      .pin_in(port_c_in),
      .analog_sel(port_c_analog_sel),
      .out_value(c_out_value),
      .dir_value(c_dir_value),
      .in_level(c_in_level),
      .pin_out(port_c_out),
      .pin_oe(port_c_oe)
   );

   // Port D keeps level and direction when retention was set
   gpio_pin_slice #(
      .W(`PORT_D_W)
   ) u_port_d (
      .clk(clk),
      .srst(srst),
      .hold(port_d_hold),
      .wr_out(wr_d_out),
      .wr_dir(wr_d_dir),
      .wdata(wdata[`PORT_D_W-1:0]),
      .pin_in(port_d_in),
      .analog_sel(port_d_analog_sel),
      .out_value(d_out_value),
      .dir_value(d_dir_value),
      .in_level(d_in_level),
      .pin_out(port_d_out),
      .pin_oe(port_d_oe)
   );

   // ----------------------------------------
   // Read select
   // ----------------------------------------
   // Input reads take the pad level of the read cycle itself, so the
   // answer is live rather than a stale snapshot
   always @* begin
      rdata_d = `READ_IDLE;
      if (hit_a_in) begin
         rdata_d = {2'b00, a_in_level};
      end else if (hit_b_in) begin
         rdata_d = b_in_level;
      end else if (hit_c_in) begin
         rdata_d = c_in_level;
      end else if (hit_d_in) begin
         rdata_d = {3'b000, d_in_level};
      end else if (hit_a_out) begin
         rdata_d = {2'b00, a_out_value};
      end else if (hit_b_out) begin
         rdata_d = b_out_value;
      end else if (hit_c_out) begin
         rdata_d = c_out_value;
      end else if (hit_d_out) begin
         rdata_d = {3'b000, d_out_value};
      end else if (hit_a_dir) begin
         rdata_d = {2'b00, a_dir_value};
      end else if (hit_b_dir) begin
         rdata_d = b_dir_value;
      end else if (hit_c_dir) begin
         rdata_d = c_dir_value;
      end else if (hit_d_dir) begin
         rdata_d = {3'b000, d_dir_value};
      end else if (hit_retain) begin
         rdata_d = {7'b0000000, retain_q};
      end
   end

   // ----------------------------------------
   // Read data register
   // ----------------------------------------
   // Data stand only in the cycle after the strobe, zero otherwise, so a
   // stale value can never be mistaken for an answer
   always @(posedge clk) begin
      if (srst) begin
         rdata_q <= `READ_IDLE;
      end else if (rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= `READ_IDLE;
      end
   end

   assign rdata = rdata_q;

endmodule // gpio_port_data_registers

// *** test/gpio_pads_model.sv ***
// Pad model: resolves each pin from the block's drive and the board's level
`timescale 1ns/1ps

module gpio_pads_model #(
   parameter W = 8
) (
   input wire [W-1:0] out,
   input wire [W-1:0] oe,
   input wire [W-1:0] ext,
   output wire [W-1:0] pad
);
   // Driven pins show the block's level, released pins the board's
   assign pad = (oe & out) | (~oe & ext);
endmodule // gpio_pads_model

// *** test/gpio_port_data_registers_checker.sv ***
// Checker for the GPIO data register block
`timescale 1ns/1ps
`include "gpio_port_map.vh"

module gpio_port_data_registers_checker (
   input wire clk,
   input wire srst,
   input wire [`GPIO_ADDR_W-1:0] addr,
   input wire [`GPIO_DATA_W-1:0] wdata,
   input wire wr,
   input wire rd,
   input wire [`GPIO_DATA_W-1:0] rdata,
   input wire [`PORT_A_W-1:0] port_a_in,
   input wire [`PORT_A_W-1:0] port_a_analog_sel,
   input wire [`PORT_A_W-1:0] port_a_out,
   input wire [`PORT_A_W-1:0] port_a_oe,
   input wire [`PORT_B_W-1:0] port_b_out,
   input wire [`PORT_B_W-1:0] port_b_oe,
   input wire [`PORT_D_W-1:0] port_d_in,
   input wire [`PORT_D_W-1:0] port_d_analog_sel,
   input wire [`PORT_D_W-1:0] port_d_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ----------------------------------------
   // Request sequences
   // ----------------------------------------
   sequence s_rd_a; rd && addr == `PORT_A_INPUT_ADDR; endsequence
   sequence s_rd_d; rd && addr == `PORT_D_INPUT_ADDR; endsequence
   sequence s_wr_b_dir; wr && addr == `PORT_B_DIRECTION_ADDR; endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_rdata_idle: assert property (!rd |=> rdata == 8'h00) else $error("rdata not idle");
   a_reset_state: assert property ($fell(srst) |-> port_a_out == 6'h00 && port_a_oe == 6'h00
      && port_b_out == 8'h00 && port_b_oe == 8'h00) else $error("bad reset state");
   a_read_a_in: assert property (s_rd_a |=> rdata == {2'b00, $past(port_a_in | port_a_analog_sel)})
      else $error("port a input read wrong");
   a_read_d_in: assert property (s_rd_d |=> rdata == {3'b000, $past(port_d_in | port_d_analog_sel)})
      else $error("port d input read wrong");
   a_write_b_out: assert property (wr && addr == `PORT_B_OUTPUT_ADDR |=> port_b_out == $past(wdata))
      else $error("port b output not updated");
   a_b_oe_hold: assert property (!(wr && addr == `PORT_B_DIRECTION_ADDR) |=> $stable(port_b_oe))
      else $error("port b oe moved");
   a_b_dir_oe: assert property (s_wr_b_dir |=> port_b_oe == ~$past(wdata))
      else $error("port b oe wrong");
   a_write_d_out: assert property (wr && addr == `PORT_D_OUTPUT_ADDR |=> port_d_out == $past(wdata[4:0]))
      else $error("port d output not updated");
   a_a_dir_oe: assert property (wr && addr == `PORT_A_DIRECTION_ADDR |=> port_a_oe == ~$past(wdata[5:0]))
      else $error("port a oe wrong");
endmodule // gpio_port_data_registers_checker

bind gpio_port_data_registers gpio_port_data_registers_checker u_chk (.clk, .srst, .addr, .wdata, .wr, .rd,
   .rdata, .port_a_in, .port_a_analog_sel, .port_a_out, .port_a_oe, .port_b_out, .port_b_oe, .port_d_in,
   .port_d_analog_sel, .port_d_out);

// *** test/testbench.sv ***
// Self-checking testbench for the GPIO data register block
`timescale 1ns/1ps
`include "gpio_port_map.vh"

module testbench;
   logic clk = 0, srst = 1, wr = 0, rd = 0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   wire [7:0] rdata;
   logic [5:0] a_ext = 6'h2a, a_sel = 6'h00;
   logic [7:0] b_ext = 8'hc3, c_ext = 8'h96, b_sel = 8'h00, c_sel = 8'h00;
   logic [4:0] d_ext = 5'h15, d_sel = 5'h00;
   wire [5:0] a_out, a_oe, a_pad;
   wire [7:0] b_out, b_oe, b_pad, c_out, c_oe, c_pad;
   wire [4:0] d_out, d_oe, d_pad;
   int num_errors = 0, samples_checked = 0;
   // Write flag, address, data or expected read value
   logic [24:0] rows [16] = '{{1'b1,16'h0080,8'ha5}, {1'b0,16'h0080,8'ha5}, {1'b1,16'h00b0,8'hff},
      {1'b0,16'h00b0,8'h3f}, {1'b1,16'h0090,8'h5a}, {1'b0,16'h0090,8'h5a}, {1'b1,16'h0098,8'hff},
      {1'b0,16'h0098,8'h1f}, {1'b1,16'h0084,8'hff}, {1'b0,16'h0084,8'h2a}, {1'b1,16'h0085,8'h00},
      {1'b0,16'h0085,8'hc3}, {1'b0,16'h0086,8'h96}, {1'b0,16'h008e,8'h15}, {1'b1,16'h1234,8'h77},
      {1'b0,16'h1234,8'h00}};

   gpio_port_data_registers u_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .port_a_in(a_pad), .port_a_analog_sel(a_sel), .port_a_out(a_out), .port_a_oe(a_oe),
      .port_b_in(b_pad), .port_b_analog_sel(b_sel), .port_b_out(b_out), .port_b_oe(b_oe),
      .port_c_in(c_pad), .port_c_analog_sel(c_sel), .port_c_out(c_out), .port_c_oe(c_oe),
      .port_d_in(d_pad), .port_d_analog_sel(d_sel), .port_d_out(d_out), .port_d_oe(d_oe));
   gpio_pads_model #(.W(6)) u_pa (.out(a_out), .oe(a_oe), .ext(a_ext), .pad(a_pad));
   gpio_pads_model #(.W(8)) u_pb (.out(b_out), .oe(b_oe), .ext(b_ext), .pad(b_pad));
   gpio_pads_model #(.W(8)) u_pc (.out(c_out), .oe(c_oe), .ext(c_ext), .pad(c_pad));
   gpio_pads_model #(.W(5)) u_pd (.out(d_out), .oe(d_oe), .ext(d_ext), .pad(d_pad));

   // ----------------------------------------
   // Clock, bus tasks, comparison
   // ----------------------------------------
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk) begin wr <= 1; addr <= a; wdata <= d; end
      @(posedge clk) wr <= 0;
      #1;
   endtask
   // Read data is only valid in the single cycle after the strobe
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk) begin rd <= 1; addr <= a; end
      @(posedge clk) rd <= 0;
      #1 chk(rdata, e);
   endtask
   task automatic pulse_reset(input int n);
      @(posedge clk) srst <= 1;
      repeat (n) @(posedge clk);
      srst <= 0;
      #1;
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------
   // Hang guard
   // ----------------------------------------
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      finish_test();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      pulse_reset(11); // Starts high, so twelve reset edges in all
      chk({2'b00, a_oe}, 8'h00);
      rd_chk(`PORT_D_RESET_RETENTION_ADDR, 8'h00);
      foreach (rows[i]) begin
         if (rows[i][24]) wr_reg(rows[i][23:8], rows[i][7:0]);
         else rd_chk(rows[i][23:8], rows[i][7:0]);
      end
      // Sensor function forces a one even on a low pad
      a_sel <= 6'h01;
      rd_chk(`PORT_A_INPUT_ADDR, 8'h2b);
      // Port D pads are released here, so the board level shows through with the analog pins read as one
      d_sel <= 5'h03;
      rd_chk(`PORT_D_INPUT_ADDR, 8'h17);
      // Output direction lets the stored level onto the pads
      wr_reg(`PORT_A_DIRECTION_ADDR, 8'h00);
      chk({2'b00, a_oe}, 8'h3f);
      rd_chk(`PORT_A_INPUT_ADDR, 8'h3f);
      // High half of port B driven, low half still follows the board
      wr_reg(`PORT_B_DIRECTION_ADDR, 8'h0f);
      chk(b_oe, 8'hf0);
      rd_chk(`PORT_B_INPUT_ADDR, 8'ha3);
      chk(b_out, 8'ha5);
      chk(c_out, 8'h5a);
      chk(c_oe, 8'h00);
      chk({2'b00, a_out}, 8'h3f);
      wr_reg(`PORT_D_OUTPUT_ADDR, 8'h0a);
      wr_reg(`PORT_D_DIRECTION_ADDR, 8'h00);
      wr_reg(`PORT_D_RESET_RETENTION_ADDR, 8'h01);
      rd_chk(`PORT_D_RESET_RETENTION_ADDR, 8'h01);
      // Several reset edges in a row must still keep port D
      pulse_reset(3);
      chk({3'b000, d_out}, 8'h0a);
      chk({3'b000, d_oe}, 8'h1f);
      chk({2'b00, a_oe}, 8'h00);
      rd_chk(`PORT_D_RESET_RETENTION_ADDR, 8'h00);
      rd_chk(`PORT_A_OUTPUT_ADDR, 8'h00);
      // Retention was consumed, so the next reset clears port D
      pulse_reset(1);
      chk({3'b000, d_out}, 8'h00);
      chk({3'b000, d_oe}, 8'h00);
      finish_test();
   end
endmodule // testbench
